//--- logic/ivpm_defines.vh
// constants for the interrupt vector and priority map
`ifndef IVPM_DEFINES_VH
`define IVPM_DEFINES_VH
`define IVPM_NUM_REQ        24
`define IVPM_NUM_LVL_REG    6
`define IVPM_LVL_BASE_ADDR  16'h0079
`define IVPM_LVL_LAST_ADDR  16'h007E
`define IVPM_LVL_RESET      8'hFF
`define IVPM_VEC_TOP        16'hFFFA
`define IVPM_NO_REQ_LEVEL   2'h3
`define IVPM_REQ_CT0_LO     5'h05
`define IVPM_REQ_CT0_HI     5'h06
`define IVPM_REQ_PG1_LO     5'h09
`define IVPM_REQ_PG1_HI     5'h0A
`define IVPM_REQ_PG0_HI     5'h0C
`define IVPM_REQ_PG0_LO     5'h0D
`define IVPM_REQ_CT1_HI     5'h0E
`define IVPM_REQ_CT1_LO     5'h16
`endif

//--- logic/ivpm_select.v
// fixed-order priority select among pending requests at the best level
`timescale 1ns/100ps
module ivpm_select #(
    parameter N = 24
) (
    input  wire [N-1:0]   pend,
    input  wire [2*N-1:0] levels,
    output reg            any,
    output reg  [4:0]     num,
    output reg  [1:0]     lvl
);
    integer i;
    always @* begin
        any = 1'b0;
        num = 5'h00;
        lvl = 2'h3;
        // walk from the highest number down so the lowest number wins ties
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (pend[i] && (!any || levels[2*i +: 2] <= lvl)) begin
                any = 1'b1;
                num = i[4:0];
                lvl = levels[2*i +: 2];
            end
        end
    end
endmodule // ivpm_select

//--- logic/ivpm_top.v
// interrupt request mapping, level registers and vector selection
// Function
// - each of requests 0..23 has its own two-bit level field
// - equal level pending together, the lowest request number is served first
// - compound timer 0 lower half to request 5, upper half to request 6
// - second pulse generator pair lower to request 9, upper to 10
// - first pulse generator pair upper to request 12, lower to 13
// - compound timer 1 upper half to request 14, lower half to 22
// - unimplemented addresses ignore writes; reads there return undefined data
// - six byte level registers from 0079, each resetting to all ones
`timescale 1ns/100ps
`include "ivpm_defines.vh"
module ivpm_top (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  ext_irq,
    input  wire        uart_sio_irq,
    input  wire        ctimer0_lo_irq,
    input  wire        ctimer0_hi_irq,
    input  wire        lin_rx_irq,
    input  wire        lin_tx_irq,
    input  wire        ppg1_lo_irq,
    input  wire        ppg1_hi_irq,
    input  wire        ppg0_hi_irq,
    input  wire        ppg0_lo_irq,
    input  wire        ctimer1_hi_irq,
    input  wire        ctimer1_lo_irq,
    input  wire        ppg16_irq,
    input  wire        i2c_irq,
    input  wire        adc_irq,
    input  wire        tbt_irq,
    input  wire        watch_irq,
    input  wire        flash_irq,
    input  wire [15:0] cpu_addr,
    input  wire        cpu_wr,
    input  wire        cpu_rd,
    input  wire [7:0]  cpu_wdata,
    output reg  [7:0]  cpu_rdata,
    output reg         irq_pending,
    output reg  [4:0]  irq_number,
    output reg  [1:0]  irq_level,
    output reg  [15:0] irq_vector_addr
);
    // widths kept local so the port list stays fixed
    localparam NREQ       = `IVPM_NUM_REQ;
    localparam NREG       = `IVPM_NUM_LVL_REG;
    localparam LVL_W      = 2;
    localparam NUM_W      = 5;
    localparam DATA_W     = 8;
    localparam ADDR_W     = 16;
    localparam PER_REG    = DATA_W / LVL_W;
    localparam VEC_STEP_W = ADDR_W - NUM_W - 1;
    // numbers 11, 17 and 21 have no source; the mask keeps them from ever pending
    localparam [NREQ-1:0] IMPL_MASK = 24'hDDF7FF;

    // request numbers of the sources without a routing rule of their own
    localparam REQ_UART  = 4;
    localparam REQ_LINRX = 7;
    localparam REQ_LINTX = 8;
    localparam REQ_GAP0  = 11;
    localparam REQ_PPG16 = 15;
    localparam REQ_I2C   = 16;
    localparam REQ_GAP1  = 17;
    localparam REQ_ADC   = 18;
    localparam REQ_TBT   = 19;
    localparam REQ_WATCH = 20;
    localparam REQ_GAP2  = 21;
    localparam REQ_FLASH = 23;

    // requests come from peripherals on this clock, so no synchroniser
    reg  [DATA_W-1:0]     level_reg [0:NREG-1];
    reg  [NREQ-1:0]       req;
    wire [NREQ-1:0]       pend;
    wire [3:0]            ext_req;
    wire [LVL_W*NREQ-1:0] levels;

    wire [NREG-1:0]       reg_sel;
    wire                  sel_any;
    wire [NUM_W-1:0]      sel_num;
    wire [LVL_W-1:0]      sel_lvl;
    wire [ADDR_W-1:0]     lvl_off;
    wire [2:0]            reg_idx;
    wire                  lvl_hit;
    wire                  wr_hit;
    wire                  rd_hit;

    // next values of the registered outputs
    reg  [DATA_W-1:0]     next_rdata;
    reg                   next_pending;
    reg  [NUM_W-1:0]      next_number;
    reg  [LVL_W-1:0]      next_level;
    reg  [ADDR_W-1:0]     next_vector;
    reg  [ADDR_W-1:0]     vec_step;
    integer               k;

    // address decode for the six level registers
    assign lvl_off = cpu_addr - `IVPM_LVL_BASE_ADDR;
    assign reg_idx = lvl_off[2:0];
    // writes outside 0079..007E fall through with no effect; reads there load zero into the read data
    assign lvl_hit = (cpu_addr >= `IVPM_LVL_BASE_ADDR) && (cpu_addr <= `IVPM_LVL_LAST_ADDR);
    assign wr_hit  = cpu_wr && lvl_hit;
    assign rd_hit  = cpu_rd && lvl_hit;

    // request map; numbers 0..3 take two external channels each, 11, 17 and 21 none, the rest one source
    always @* begin
        req                   = {NREQ{1'b0}};
        req[3:0]              = ext_req;
        req[REQ_UART]         = uart_sio_irq;
        req[`IVPM_REQ_CT0_LO] = ctimer0_lo_irq;
        req[`IVPM_REQ_CT0_HI] = ctimer0_hi_irq;
        req[REQ_LINRX]        = lin_rx_irq;
        req[REQ_LINTX]        = lin_tx_irq;
        req[`IVPM_REQ_PG1_LO] = ppg1_lo_irq;
        req[`IVPM_REQ_PG1_HI] = ppg1_hi_irq;
        req[REQ_GAP0]         = 1'b0;
        req[`IVPM_REQ_PG0_HI] = ppg0_hi_irq;
        req[`IVPM_REQ_PG0_LO] = ppg0_lo_irq;
        req[`IVPM_REQ_CT1_HI] = ctimer1_hi_irq;
        req[REQ_PPG16]        = ppg16_irq;
        req[REQ_I2C]          = i2c_irq;
        req[REQ_GAP1]         = 1'b0;
        req[REQ_ADC]          = adc_irq;
        req[REQ_TBT]          = tbt_irq;
        req[REQ_WATCH]        = watch_irq;
        req[REQ_GAP2]         = 1'b0;
        req[`IVPM_REQ_CT1_LO] = ctimer1_lo_irq;
        req[REQ_FLASH]        = flash_irq;
    end

    assign pend = req & IMPL_MASK;

    // each level register holds four two-bit fields, lowest request in bits 1:0
    genvar g;
    generate
        // external channels n and n+4 share request n
        for (g = 0; g < 4; g = g + 1) begin : g_ext
            assign ext_req[g] = ext_irq[g] | ext_irq[g+4];
        end

        for (g = 0; g < NREQ; g = g + 1) begin : g_lvl
            assign levels[LVL_W*g +: LVL_W] = level_reg[g/PER_REG][LVL_W*(g%PER_REG) +: LVL_W];
        end

        // write strobe per level register
        for (g = 0; g < NREG; g = g + 1) begin : g_sel
            assign reg_sel[g] = wr_hit && (reg_idx == g);
        end
    endgenerate

    // one process owns the whole array, so each entry has a single driver
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (k = 0; k < NREG; k = k + 1) begin
                level_reg[k] <= `IVPM_LVL_RESET;
            end
        end else begin
            for (k = 0; k < NREG; k = k + 1) begin
                if (reg_sel[k]) begin
                    level_reg[k] <= cpu_wdata;
                end
            end
        end
    end

    ivpm_select #(
        .N (NREQ)
    ) u_select (
        .pend   (pend),
        .levels (levels),
        .any    (sel_any),
        .num    (sel_num),
        .lvl    (sel_lvl)
    );

    // undefined reads are driven as zero, software must not rely on it
    always @* begin
        next_rdata = cpu_rdata;
        if (rd_hit) begin
            next_rdata = level_reg[reg_idx];
        end else if (cpu_rd) begin
            next_rdata = 8'h00;
        end
    end

    // the vector steps down two bytes per request number
    always @* begin
        vec_step     = {{VEC_STEP_W{1'b0}}, sel_num, 1'b0};
        next_pending = sel_any;
        next_number  = sel_num;
        next_level   = sel_lvl;
        next_vector  = `IVPM_VEC_TOP - vec_step;
        if (!sel_any) begin
            // idle outputs rest at the reset pattern, a stale winner is never shown
            next_number = 5'h00;
            next_level  = `IVPM_NO_REQ_LEVEL;
            next_vector = `IVPM_VEC_TOP;
        end
    end

    // read data stands until the next read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_rdata <= 8'h00;
        end else begin
            cpu_rdata <= next_rdata;
        end
    end

    // every output is a flip-flop so the core sees a settled vector
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_pending     <= 1'b0;
            irq_number      <= 5'h00;
            irq_level       <= `IVPM_NO_REQ_LEVEL;
            irq_vector_addr <= `IVPM_VEC_TOP;
        end else begin
            irq_pending     <= next_pending;
            irq_number      <= next_number;
            irq_level       <= next_level;
            irq_vector_addr <= next_vector;
        end
    end
endmodule // ivpm_top

//--- tb/ivpm_cpu.sv
// cpu side model: takes the vector of the winning request
`timescale 1ns/100ps
module ivpm_cpu (
    input  wire        clk,
    input  wire        irq_pending,
    input  wire [15:0] irq_vector_addr,
    output reg  [15:0] fetch_addr
);
    // takes a vector only while a request stands, never a stale one
    always @(posedge clk) if (irq_pending) fetch_addr <= irq_vector_addr;
endmodule // ivpm_cpu

//--- tb/ivpm_monitor.sv
// checker for the request map, vectors and level register ports
`timescale 1ns/100ps
module ivpm_monitor (
    input wire        clk,
    input wire        rst,
    input wire [7:0]  ext_irq,
    input wire        ctimer0_lo_irq,
    input wire        ctimer0_hi_irq,
    input wire [15:0] cpu_addr,
    input wire        cpu_wr,
    input wire        cpu_rd,
    input wire [7:0]  cpu_wdata,
    input wire [7:0]  cpu_rdata,
    input wire        irq_pending,
    input wire [4:0]  irq_number,
    input wire [1:0]  irq_level,
    input wire [15:0] irq_vector_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    vec_map_a: assert property (irq_pending |-> irq_vector_addr == 16'hFFFA - {irq_number, 1'b0}) else $error("vec");
    ext_pend_a: assert property (ext_irq != 8'h00 |=> irq_pending) else $error("pend");
    ext_top_a: assert property (ext_irq[0] | ext_irq[4] |=> irq_number == 5'h00 || irq_level != 2'h3) else $error("ord");
    ct0_lo_a: assert property (irq_pending && irq_number == 5'h05 |-> $past(ctimer0_lo_irq)) else $error("lo");
    ct0_hi_a: assert property (irq_pending && irq_number == 5'h06 |-> $past(ctimer0_hi_irq)) else $error("hi");
    unmap_rd_a: assert property (cpu_rd && !(cpu_addr inside {[16'h0079:16'h007E]}) |=> cpu_rdata == 8'h00) else $error("um");
    wr_rd_a: assert property (cpu_wr && cpu_addr == 16'h0079 ##1 cpu_rd && !cpu_wr && cpu_addr == 16'h0079
        |=> cpu_rdata == $past(cpu_wdata, 2)) else $error("reg");
    rd_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata)) else $error("hold");
    cover property (irq_pending && irq_number == 5'h06 && irq_level == 2'h0);
    cover property (cpu_rd && cpu_addr == 16'h007F);
    cover property (irq_pending && irq_number == 5'h17);
endmodule // ivpm_monitor
bind ivpm_top ivpm_monitor u_ivpm_monitor (.*);

//--- tb/tb.sv
// self-checking bench for the request map and level registers
`timescale 1ns/100ps
module tb;
    reg         clk = 0, rst = 1, cpu_wr = 0, cpu_rd = 0;
    reg  [7:0]  ext_irq = 8'h00, cpu_wdata = 8'h00;
    reg  [16:0] p = 17'h00000;
    reg  [15:0] cpu_addr = 16'h0000;
    wire [7:0]  cpu_rdata;
    wire        irq_pending;
    wire [4:0]  irq_number;
    wire [1:0]  irq_level;
    wire [15:0] irq_vector_addr, fetch_addr, e;
    integer     n_fail = 0, n_tests = 0, i;
    // bit i of p drives one peripheral; e is its request number
    assign e = i < 7 ? i + 4 : i < 12 ? i + 5 : i < 15 ? i + 6 : i + 7;
    ivpm_top u_ivpm_top (.*, .uart_sio_irq(p[0]), .ctimer0_lo_irq(p[1]), .ctimer0_hi_irq(p[2]), .lin_rx_irq(p[3]),
        .lin_tx_irq(p[4]), .ppg1_lo_irq(p[5]), .ppg1_hi_irq(p[6]), .ppg0_hi_irq(p[7]), .ppg0_lo_irq(p[8]),
        .ctimer1_hi_irq(p[9]), .ppg16_irq(p[10]), .i2c_irq(p[11]), .adc_irq(p[12]), .tbt_irq(p[13]),
        .watch_irq(p[14]), .ctimer1_lo_irq(p[15]), .flash_irq(p[16]));
    ivpm_cpu u_ivpm_cpu (.*);
    initial forever #2 clk = ~clk;
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one bus cycle per call; strobes held until the next rising edge
    task cyc(input w, input r, input [15:0] ad, input [7:0] d);
        begin
            {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {w, r, ad, d};
            @(posedge clk) #1;
        end
    endtask
    task t_reset;
        begin
            chk(cpu_rdata, 8'h00);
            cyc(0, 1, 16'h0079, 0); chk(cpu_rdata, 8'hFF);
            cyc(0, 1, 16'h007E, 0); cyc(0, 0, 0, 0); chk(cpu_rdata, 8'hFF);
        end
    endtask
    task t_route;
        for (i = 0; i < 17; i = i + 1) begin
            p = 17'h00001 << i; @(posedge clk) #1 p = 0;
            chk(irq_number, e);
            chk(irq_vector_addr, 16'hFFFA - 2 * e);
            @(posedge clk) #1 chk(fetch_addr, 16'hFFFA - 2 * e);
        end
    endtask
    task t_prio;
        begin
            ext_irq = 8'h10; p = 16'h0006; @(posedge clk) #1 chk(irq_number, 5'h00);
            ext_irq = 8'h00; @(posedge clk) #1 chk(irq_number, 5'h05);
            p = 0;
        end
    endtask
    task t_regs;
        begin
            cyc(1, 0, 16'h0079, 8'hE4); cyc(0, 1, 16'h0079, 0); cyc(0, 0, 0, 0); chk(cpu_rdata, 8'hE4);
            cyc(1, 0, 16'h007F, 8'h55); cyc(0, 1, 16'h007F, 0); cyc(0, 0, 0, 0); chk(cpu_rdata, 8'h00);
        end
    endtask
    task t_level;
        begin
            cyc(1, 0, 16'h007A, 8'hCF); cyc(0, 0, 0, 0); p = 16'h0006;
            @(posedge clk) #1 chk(irq_number, 5'h06);
            chk(irq_level, 2'h0);
            p = 0;
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        t_reset; t_route; t_prio; t_regs; t_level; end_of_test;
    end
    // the run needs some 58 cycles; give it about seventeen times that
    initial begin
        #4000 n_fail = n_fail + 1;
        end_of_test;
    end
endmodule // tb
